// ### common/rtcirq_pkg.sv
// package: register map, field positions, timing constants and carriers of the rtc irq block
package rtcirq_pkg;
   // register indices
   localparam logic [3:0] ADDR_INT_CLOCK_CONTROL = 4'hE;
   localparam logic [3:0] ADDR_STATUS_FLAG_CONTROL = 4'hF;
   // interrupt_clock_control fields
   localparam int C1_WEEKLY_ALARM_EN = 7;
   localparam int C1_DAILY_ALARM_EN = 6;
   localparam int C1_CLKOUT_EN_N_B = 4;
   localparam int C1_PERIODIC_SEL_LO = 0;
   // status_flag_control fields
   localparam int C2_OSC_STOP_FLAG = 5;
   localparam int C2_CLKOUT_EN_N_A = 3;
   localparam int C2_PERIODIC_FLAG = 2;
   localparam int C2_WEEKLY_ALARM_FLAG = 1;
   localparam int C2_DAILY_ALARM_FLAG = 0;
   // stored bits of status_flag_control (bit 5 reads the live stop flag)
   localparam logic [7:0] C2_STORE_MASK = 8'hDF;
   localparam logic [7:0] C1_RESET = 8'h00;
   localparam logic [7:0] C2_RESET = 8'h00;
   // periodic select codes
   localparam logic [2:0] PER_OFF = 3'h0;
   localparam logic [2:0] PER_LOW = 3'h1;
   localparam logic [2:0] PER_PULSE_2HZ = 3'h2;
   localparam logic [2:0] PER_PULSE_1HZ = 3'h3;
   localparam logic [2:0] PER_LEVEL_SEC = 3'h4;
   localparam logic [2:0] PER_LEVEL_MIN = 3'h5;
   localparam logic [2:0] PER_LEVEL_HOUR = 3'h6;
   localparam logic [2:0] PER_LEVEL_MONTH = 3'h7;
   // crystal chain timing
   localparam int XTAL_HZ = 32768;
   localparam int INC_DELAY_US = 92;
   localparam int INC_DELAY_TICKS = (INC_DELAY_US * XTAL_HZ) / 1000000;
   localparam int ADJ_PERIOD_S = 20;
   localparam int ADJ_MAX_US = 3784;
   localparam int ADJ_MAX_TICKS = (ADJ_MAX_US * XTAL_HZ) / 1000000;
   localparam logic signed [15:0] DIV_LAST = 16'sh7FFF;
   localparam logic signed [15:0] DIV_HALF = 16'sh4000;
   localparam int DIV_2HZ_BIT = 13;
   // carriers
   typedef struct packed {
      logic [3:0] addr;
      logic wr;
      logic [7:0] wdata;
   } rtcirq_reg_req_type;
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [2:0] wday;
   } rtcirq_time_type;
   typedef struct packed {
      logic [6:0] w_wday_mask;
      logic [7:0] w_hour;
      logic [7:0] w_min;
      logic [7:0] d_hour;
      logic [7:0] d_min;
   } rtcirq_alarm_type;
endpackage

// ### rtl/rtcirq_core.sv
// alarm, periodic interrupt and 32 kHz clock output logic of the real-time clock
//
// Overview of operation
// - irq_out_n pulled low when current time matches an enabled alarm setting.
// - weekly alarm flag at status bit 1, enabled by control bit 7.
// - daily alarm flag at status bit 0, enabled by control bit 6.
// - periodic flag at status bit 2; select field bits 2..0, zero disables.
// - all enables and select zero keeps interrupt line released.
// - interrupt line low while any source asserts.
// - each alarm works only while its enable bit is one.
// - alarm flag reads state; writing one keeps it, zero clears it.
// - clearing a flag leaves the enables armed for the next match.
// - codes 000 off, 001 low, 010 2Hz, 011 1Hz square waves.
// - codes 1xx level mode: each second, minute, hour, month start.
// - level mode holds line low until software clears periodic flag.
// - pulse mode: second increments about 92 us after falling edge.
// - level mode falling edge coincides with second increment.
// - adjustment shifts the one second cycle every 20 seconds, bounded.
// - second counter write resets the sub-second divider, pulse goes low.
// - clock output runs when control pin high and an enable bit zero.
// - clock output static when disabled; low level chosen.
// - oscillation stop clears enables, select, clock enables and flags.
`timescale 1ns/100ps
`default_nettype none
module rtcirq_core (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire rtcirq_pkg::rtcirq_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   // time counters and alarm settings
   input wire rtcirq_pkg::rtcirq_time_type cur_time,
   input wire rtcirq_pkg::rtcirq_alarm_type alarm_set,
   input wire logic sec_write,
   output logic sec_inc,
   // oscillation
   input wire logic osc_stop_flag,
   input wire logic osc_adj_en,
   input wire logic signed [7:0] osc_adj_ticks,
   input wire logic xtal_pin,
   // pins
   input wire logic clkout_ctrl_pin,
   output logic crystal_clock_out,
   output logic irq_out_n_o,
   output logic irq_out_n_oe_n
);
   import rtcirq_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [2:0] xtal_sync;
      logic xtal_lvl;
      logic [2:0] ctl_sync;
      logic ctl_lvl;
      logic signed [15:0] div;
      logic [1:0] inc_dly;
      logic inc_busy;
      logic [4:0] adj_sec;
      logic inc_q;
      logic inc_qq;
      logic wk_match;
      logic dy_match;
      logic osc_stop;
      logic wave_low;
      logic gate;
      logic clk_out;
      logic drive;
      logic [7:0] rdata;
   } rtcirq_state_type;

   rtcirq_state_type q;
   rtcirq_state_type d;

   // weekday mask lookup, wday 7 never hits
   function automatic logic wday_hit(input logic [6:0] mask, input logic [2:0] wday);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (wday == i[2:0]) begin
            hit = mask[i];
         end
      end
      return hit;
   endfunction

   // synchroniser: new level once stages two and three agree
   function automatic logic sync_settle(input logic [2:0] s, input logic lvl);
      return (s[1] == s[2]) ? s[2] : lvl;
   endfunction

   logic xtal_rise;
   logic wk_match;
   logic dy_match;
   logic lvl_event;
   logic wave_low;
   logic per_drive;
   logic osc_rise;
   logic signed [7:0] adj_lim;
   logic [2:0] sel;

   always_comb begin
      d = q;
      d.inc_q = 1'b0;
      d.inc_qq = q.inc_q;
      d.xtal_sync = {q.xtal_sync[1:0], xtal_pin};
      d.ctl_sync = {q.ctl_sync[1:0], clkout_ctrl_pin};
      d.xtal_lvl = sync_settle(q.xtal_sync, q.xtal_lvl);
      d.ctl_lvl = sync_settle(q.ctl_sync, q.ctl_lvl);
      xtal_rise = d.xtal_lvl && !q.xtal_lvl;
      sel = q.ctrl1[C1_PERIODIC_SEL_LO +: 3];
      // adjustment bounded so the shift never exceeds the documented span
      adj_lim = osc_adj_ticks;
      if (osc_adj_ticks > 8'(ADJ_MAX_TICKS)) begin
         adj_lim = 8'(ADJ_MAX_TICKS);
      end else if (osc_adj_ticks < -8'(ADJ_MAX_TICKS)) begin
         adj_lim = -8'(ADJ_MAX_TICKS);
      end

      // sub-second divider; wrap is the falling edge of both waves
      if (xtal_rise) begin
         if (q.div == DIV_LAST) begin
            d.div = 16'sh0000;
            d.inc_busy = 1'b1;
            d.inc_dly = 2'h0;
            if (q.adj_sec == 5'(ADJ_PERIOD_S - 1)) begin
               d.adj_sec = 5'h00;
               if (osc_adj_en) begin
                  d.div = -16'(adj_lim);
               end
            end else begin
               d.adj_sec = q.adj_sec + 5'h01;
            end
         end else begin
            d.div = q.div + 16'sh0001;
         end
         if (q.inc_busy) begin
            if (q.inc_dly == 2'(INC_DELAY_TICKS - 1)) begin
               d.inc_busy = 1'b0;
               d.inc_q = 1'b1;
            end else begin
               d.inc_dly = q.inc_dly + 2'h1;
            end
         end
      end
      if (sec_write) begin
         d.div = 16'sh0000;
         d.inc_busy = 1'b0;
         d.inc_dly = 2'h0;
      end

      // pulse waves low in the first half of each period
      if (sel == PER_PULSE_2HZ) begin
         wave_low = (d.div < 16'sh0000) || !d.div[DIV_2HZ_BIT];
      end else begin
         wave_low = d.div < DIV_HALF;
      end
      d.wave_low = wave_low;

      // counters have taken the increment by inc_qq
      lvl_event = 1'b0;
      if (q.inc_qq) begin
         unique case (sel)
            PER_LEVEL_SEC: lvl_event = 1'b1;
            PER_LEVEL_MIN: lvl_event = cur_time.sec == 8'h00;
            PER_LEVEL_HOUR: lvl_event = cur_time.sec == 8'h00 && cur_time.min == 8'h00;
            PER_LEVEL_MONTH: lvl_event = cur_time.sec == 8'h00 && cur_time.min == 8'h00
                                         && cur_time.hour == 8'h00 && cur_time.day == 8'h01;
            default: lvl_event = 1'b0;
         endcase
      end

      wk_match = q.ctrl1[C1_WEEKLY_ALARM_EN] && wday_hit(alarm_set.w_wday_mask, cur_time.wday)
                 && cur_time.hour == alarm_set.w_hour && cur_time.min == alarm_set.w_min;
      dy_match = q.ctrl1[C1_DAILY_ALARM_EN]
                 && cur_time.hour == alarm_set.d_hour && cur_time.min == alarm_set.d_min;
      d.wk_match = wk_match;
      d.dy_match = dy_match;

      // register writes; a status write never touches the interrupt_clock_control enables
      if (reg_req.wr && reg_req.addr == ADDR_INT_CLOCK_CONTROL) begin
         d.ctrl1 = reg_req.wdata;
      end
      if (reg_req.wr && reg_req.addr == ADDR_STATUS_FLAG_CONTROL) begin
         d.ctrl2 = reg_req.wdata & C2_STORE_MASK;
         // flags only clear on zero, a one keeps them
         d.ctrl2[2:0] = q.ctrl2[2:0] & reg_req.wdata[2:0];
      end
      // match edges set the flags, winning over a same-cycle clear
      if (wk_match && !q.wk_match) begin
         d.ctrl2[C2_WEEKLY_ALARM_FLAG] = 1'b1;
      end
      if (dy_match && !q.dy_match) begin
         d.ctrl2[C2_DAILY_ALARM_FLAG] = 1'b1;
      end
      // both waveform modes set the periodic flag at the falling edge
      if (lvl_event || ((sel == PER_PULSE_2HZ || sel == PER_PULSE_1HZ) && wave_low
                        && !q.wave_low)) begin
         d.ctrl2[C2_PERIODIC_FLAG] = 1'b1;
      end
      // stop event clears everything it owns
      d.osc_stop = osc_stop_flag;
      osc_rise = osc_stop_flag && !q.osc_stop;
      if (osc_rise) begin
         d.ctrl1 = C1_RESET;
         d.ctrl2 = C2_RESET;
      end

      // select field steers the periodic drive
      unique case (d.ctrl1[C1_PERIODIC_SEL_LO +: 3])
         PER_OFF: per_drive = 1'b0;
         PER_LOW: per_drive = 1'b1;
         PER_PULSE_2HZ, PER_PULSE_1HZ: per_drive = wave_low;
         // level mode follows the flag until software clears it
         default: per_drive = d.ctrl2[C2_PERIODIC_FLAG];
      endcase
      // wired-or of the negative-logic requests, idle when all off
      d.drive = (d.ctrl2[C2_WEEKLY_ALARM_FLAG] && d.ctrl1[C1_WEEKLY_ALARM_EN])
                || (d.ctrl2[C2_DAILY_ALARM_FLAG] && d.ctrl1[C1_DAILY_ALARM_EN]) || per_drive;

      // gate moves only in the low phase, so no runt pulses
      if (!q.xtal_lvl && !d.xtal_lvl) begin
         // pin high and either active-low enable at zero
         d.gate = q.ctl_lvl && (!q.ctrl1[C1_CLKOUT_EN_N_B] || !q.ctrl2[C2_CLKOUT_EN_N_A]);
      end
      d.clk_out = q.xtal_lvl && q.gate;

      // read data one cycle after the address; unmapped reads zero
      if (reg_req.addr == ADDR_INT_CLOCK_CONTROL) begin
         d.rdata = q.ctrl1;
      end else if (reg_req.addr == ADDR_STATUS_FLAG_CONTROL) begin
         d.rdata = q.ctrl2 | {2'h0, osc_stop_flag, 5'h00};
      end else begin
         d.rdata = 8'h00;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign sec_inc = q.inc_q;
   assign crystal_clock_out = q.clk_out;
   assign irq_out_n_o = 1'b0;
   assign irq_out_n_oe_n = !q.drive;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   a_weekly_alarm_drive: assert property (
      q.ctrl2[C2_WEEKLY_ALARM_FLAG] && q.ctrl1[C1_WEEKLY_ALARM_EN] |-> !irq_out_n_oe_n)
      else $error("weekly alarm flag set but line released");

   a_daily_alarm_drive: assert property (
      q.ctrl2[C2_DAILY_ALARM_FLAG] && q.ctrl1[C1_DAILY_ALARM_EN] |-> !irq_out_n_oe_n)
      else $error("daily alarm flag set but line released");

   a_idle_line_released: assert property (
      q.ctrl1[7:6] == 2'h0 && q.ctrl1[2:0] == PER_OFF |-> irq_out_n_oe_n)
      else $error("line driven with all sources disabled");

   a_flag_write_one: assert property (
      reg_req.wr && reg_req.addr == ADDR_STATUS_FLAG_CONTROL && reg_req.wdata[1]
      && q.ctrl2[1] && !(osc_stop_flag && !q.osc_stop) |=> q.ctrl2[1])
      else $error("writing one changed the weekly flag");

   a_clear_keeps_enable: assert property (
      reg_req.wr && reg_req.addr == ADDR_STATUS_FLAG_CONTROL
      && !(osc_stop_flag && !q.osc_stop) |=> $stable(q.ctrl1))
      else $error("flag clear disturbed the enable bits");

   a_fixed_low_code: assert property (
      q.ctrl1[2:0] == PER_LOW |-> !irq_out_n_oe_n)
      else $error("code 001 does not hold the line low");

   a_level_hold: assert property (
      q.ctrl1[2] && q.ctrl2[C2_PERIODIC_FLAG] |-> !irq_out_n_oe_n)
      else $error("level mode released before flag clear");

   a_second_write_reset: assert property (
      sec_write |=> q.div == 16'sh0000 && !q.inc_busy ##1 !sec_inc)
      else $error("second write did not reset the divider");

   a_osc_stop_clear: assert property (
      osc_stop_flag && !q.osc_stop |=> q.ctrl1 == 8'h00 && q.ctrl2 == 8'h00 ##1 irq_out_n_oe_n)
      else $error("stop event did not clear control bits");

   a_gate_edge_clean: assert property (
      $changed(q.gate) |-> !$past(q.xtal_lvl) && !q.xtal_lvl)
      else $error("clock gate changed during high phase");

   a_weekly_enable_gate: assert property (
      !$past(q.ctrl1[C1_WEEKLY_ALARM_EN]) |-> !q.wk_match)
      else $error("weekly match seen while disabled");

   a_daily_enable_gate: assert property (
      !$past(q.ctrl1[C1_DAILY_ALARM_EN]) |-> !q.dy_match)
      else $error("daily match seen while disabled");

   a_weekly_match_flag: assert property (
      wk_match && !q.wk_match && !osc_rise |=> q.ctrl2[C2_WEEKLY_ALARM_FLAG])
      else $error("weekly match did not set its flag");

   a_daily_match_flag: assert property (
      dy_match && !q.dy_match && !osc_rise |=> q.ctrl2[C2_DAILY_ALARM_FLAG])
      else $error("daily match did not set its flag");

   a_weekly_zero_clear: assert property (
      reg_req.wr && reg_req.addr == ADDR_STATUS_FLAG_CONTROL
      && !reg_req.wdata[C2_WEEKLY_ALARM_FLAG] && !(wk_match && !q.wk_match)
      |=> !q.ctrl2[C2_WEEKLY_ALARM_FLAG])
      else $error("writing zero left the weekly flag set");

   a_daily_zero_clear: assert property (
      reg_req.wr && reg_req.addr == ADDR_STATUS_FLAG_CONTROL
      && !reg_req.wdata[C2_DAILY_ALARM_FLAG] && !(dy_match && !q.dy_match)
      |=> !q.ctrl2[C2_DAILY_ALARM_FLAG])
      else $error("writing zero left the daily flag set");

   a_inc_one_cycle: assert property (
      sec_inc |=> !sec_inc)
      else $error("second increment longer than one cycle");

   a_level_event_flag: assert property (
      lvl_event && !osc_rise |=> q.ctrl2[C2_PERIODIC_FLAG])
      else $error("level event did not set the periodic flag");

   a_pulse_edge_flag: assert property (
      (sel == PER_PULSE_2HZ || sel == PER_PULSE_1HZ) && wave_low && !q.wave_low
      && !osc_rise |=> q.ctrl2[C2_PERIODIC_FLAG])
      else $error("pulse falling edge did not set the periodic flag");

   a_gate_opens: assert property (
      q.ctl_lvl && !q.ctrl1[C1_CLKOUT_EN_N_B] && !q.xtal_lvl && !d.xtal_lvl |=> q.gate)
      else $error("clock gate stayed shut while enabled");

   a_gate_off_low: assert property (
      !q.gate |=> !crystal_clock_out)
      else $error("clock output moved while gated off");

endmodule
`default_nettype wire

// ### tb/rtcirq_host_model.sv
// host side model: pulled-up interrupt input and clock output monitor
`timescale 1ns/100ps
`default_nettype none
module rtcirq_host_model (
   // clock
   input wire logic clock,
   // device pins
   input wire logic irq_out_n_o,
   input wire logic irq_out_n_oe_n,
   input wire logic crystal_clock_out,
   // observations
   output logic irq_line,
   output var int clk_edges,
   output var int min_high
);
   int high_len = 0;
   int edges_q = 0;
   int min_q = 1000;
   logic prev_q = 1'b0;
   // released line floats to the pull-up level
   assign irq_line = irq_out_n_oe_n ? 1'b1 : irq_out_n_o;
   assign clk_edges = edges_q;
   assign min_high = min_q;
   // shortest high phase, a runt shows as a short one
   always @(posedge clock) begin
      prev_q <= crystal_clock_out;
      if (crystal_clock_out && !prev_q) edges_q <= edges_q + 1;
      high_len <= crystal_clock_out ? high_len + 1 : 0;
      if (!crystal_clock_out && prev_q && high_len < min_q) min_q <= high_len;
   end
endmodule
`default_nettype wire

// ### tb/tb_rtcirq_core.sv
// bench for the alarm, periodic and clock output block
`timescale 1ns/100ps
`default_nettype none
module tb_rtcirq_core;
   import rtcirq_pkg::*;
   typedef struct packed {logic [7:0] ctl; logic [7:0] flags; logic irq_n;} rtcirq_row_type;
   logic clock, arst_n, sec_write, osc_stop_flag, osc_adj_en, xtal_pin, clkout_ctrl_pin;
   logic signed [7:0] osc_adj_ticks;
   rtcirq_reg_req_type reg_req;
   rtcirq_time_type cur_time;
   rtcirq_alarm_type alarm_set;
   logic [7:0] reg_rdata;
   logic sec_inc, crystal_clock_out, irq_out_n_o, irq_out_n_oe_n, irq_line;
   int clk_edges, min_high;
   int failures = 0;
   int checks = 0;
   rtcirq_row_type rows [5] = '{'{8'h80, 8'h02, 1'b0}, '{8'h40, 8'h01, 1'b0},
      '{8'h00, 8'h00, 1'b1}, '{8'h01, 8'h00, 1'b0}, '{8'hC0, 8'h03, 1'b0}};

   rtcirq_core rtcirq_core_i (.clock(clock), .arst_n(arst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .cur_time(cur_time), .alarm_set(alarm_set),
      .sec_write(sec_write), .sec_inc(sec_inc), .osc_stop_flag(osc_stop_flag),
      .osc_adj_en(osc_adj_en), .osc_adj_ticks(osc_adj_ticks), .xtal_pin(xtal_pin),
      .clkout_ctrl_pin(clkout_ctrl_pin), .crystal_clock_out(crystal_clock_out),
      .irq_out_n_o(irq_out_n_o), .irq_out_n_oe_n(irq_out_n_oe_n));
   rtcirq_host_model rtcirq_host_model_i (.clock(clock), .irq_out_n_o(irq_out_n_o),
      .irq_out_n_oe_n(irq_out_n_oe_n), .crystal_clock_out(crystal_clock_out),
      .irq_line(irq_line), .clk_edges(clk_edges), .min_high(min_high));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // crystal much faster than real so the gate sees many edges; phase unrelated
   initial begin
      xtal_pin = 1'b0;
      #7.3;
      forever #15 xtal_pin = ~xtal_pin;
   end

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req = '{addr: a, wr: 1'b1, wdata: d};
      @(negedge clock);
      reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_req.addr = a;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task automatic pulse_sec_write;
      @(negedge clock);
      sec_write = 1'b1;
      @(negedge clock);
      sec_write = 1'b0;
   endtask
   task automatic rematch;
      cur_time.min = 8'h31;
      @(negedge clock);
      cur_time.min = 8'h30;
      repeat (4) @(negedge clock);
   endtask
   task automatic run_gate(input logic exp_runs);
      int n0;
      repeat (40) @(negedge clock);
      n0 = clk_edges;
      repeat (400) @(negedge clock);
      check_bit(clk_edges > n0, exp_runs);
      if (!exp_runs) check_bit(crystal_clock_out, 1'b0);
   endtask

   initial begin
      #400us;
      failures++;
      report_and_stop();
   end

   initial begin
      logic [7:0] v;
      arst_n = 1'b0;
      reg_req = '0;
      sec_write = 1'b0;
      osc_stop_flag = 1'b0;
      osc_adj_en = 1'b0;
      osc_adj_ticks = 8'sh00;
      clkout_ctrl_pin = 1'b1;
      alarm_set = '{w_wday_mask: 7'h08, w_hour: 8'h12, w_min: 8'h30, d_hour: 8'h12, d_min: 8'h30};
      cur_time = '{sec: 8'h00, min: 8'h31, hour: 8'h12, day: 8'h05, wday: 3'h3};
      repeat (6) @(negedge clock);
      check_byte(reg_rdata, 8'h00);
      check_bit(irq_line, 1'b1);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         // disarm before touching the alarm setup
         wr(ADDR_INT_CLOCK_CONTROL, 8'h00);
         wr(ADDR_STATUS_FLAG_CONTROL, 8'h00);
         wr(ADDR_INT_CLOCK_CONTROL, rows[i].ctl);
         rematch();
         check_bit(irq_line, rows[i].irq_n);
         rd(ADDR_STATUS_FLAG_CONTROL, v);
         check_byte(v & 8'h03, rows[i].flags);
      end
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h03);
      rd(ADDR_STATUS_FLAG_CONTROL, v);
      check_byte(v & 8'h03, 8'h03);
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h02);
      rd(ADDR_STATUS_FLAG_CONTROL, v);
      check_byte(v & 8'h03, 8'h02);
      check_bit(irq_line, 1'b0);
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h00);
      check_bit(irq_line, 1'b1);
      rd(ADDR_INT_CLOCK_CONTROL, v);
      check_byte(v, 8'hC0);
      rematch();
      check_bit(irq_line, 1'b0);
      wr(4'h3, 8'hFF);
      rd(4'h3, v);
      check_byte(v, 8'h00);
      rd(ADDR_INT_CLOCK_CONTROL, v);
      check_byte(v, 8'hC0);
      wr(ADDR_INT_CLOCK_CONTROL, 8'hD1);
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h08);
      osc_stop_flag = 1'b1;
      repeat (3) @(negedge clock);
      rd(ADDR_INT_CLOCK_CONTROL, v);
      check_byte(v, 8'h00);
      rd(ADDR_STATUS_FLAG_CONTROL, v);
      check_byte(v, 8'h20);
      check_bit(irq_line, 1'b1);
      osc_stop_flag = 1'b0;
      run_gate(1'b1);
      wr(ADDR_INT_CLOCK_CONTROL, 8'h10);
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h08);
      run_gate(1'b0);
      wr(ADDR_INT_CLOCK_CONTROL, 8'h00);
      run_gate(1'b1);
      clkout_ctrl_pin = 1'b0;
      run_gate(1'b0);
      clkout_ctrl_pin = 1'b1;
      run_gate(1'b1);
      check_bit(min_high >= 3, 1'b1);
      // periodic output; one crystal tick is six clocks here
      pulse_sec_write();
      wr(ADDR_INT_CLOCK_CONTROL, 8'h02);
      check_bit(irq_line, 1'b0);
      repeat (55000) @(negedge clock);
      check_bit(irq_line, 1'b1);
      check_bit(sec_inc, 1'b0);
      rd(ADDR_STATUS_FLAG_CONTROL, v);
      check_byte(v & 8'h04, 8'h00);
      pulse_sec_write();
      check_bit(irq_line, 1'b0);
      rd(ADDR_STATUS_FLAG_CONTROL, v);
      check_byte(v & 8'h04, 8'h04);
      wr(ADDR_INT_CLOCK_CONTROL, 8'h04);
      check_bit(irq_line, 1'b0);
      wr(ADDR_STATUS_FLAG_CONTROL, 8'h00);
      check_bit(irq_line, 1'b1);
      // reset in mid-run with the line held low
      wr(ADDR_INT_CLOCK_CONTROL, 8'h01);
      check_bit(irq_line, 1'b0);
      arst_n = 1'b0;
      repeat (2) @(negedge clock);
      check_bit(irq_line, 1'b1);
      check_byte(reg_rdata, 8'h00);
      arst_n = 1'b1;
      rd(ADDR_INT_CLOCK_CONTROL, v);
      check_byte(v, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
